// ===== lvrf_pkg.sv
// lvrf_pkg: constants and types of the low voltage reset filter
// assumes one 25 MHz clock and a plain strobe register port
package lvrf_pkg;
  // ==================================================
  // register port
  localparam int unsigned AW = 3;
  localparam int unsigned DW = 8;
  localparam logic [2:0] ADDR_STATUS_CTRL = 3'h0;
  localparam logic [2:0] ADDR_CONFIG      = 3'h1;
  localparam logic [2:0] ADDR_EVT_STATUS  = 3'h2;
  localparam logic [2:0] ADDR_EVT_MASK    = 3'h3;
  // ==================================================
  // field positions
  localparam int unsigned BIT_TRIP_SEL  = 0; // status_control
  localparam int unsigned BIT_UV_FLAG   = 7; // status_control
  localparam int unsigned BIT_PWR_EN    = 0; // config
  localparam int unsigned BIT_RST_EN    = 1; // config
  localparam int unsigned BIT_EVT_FLAG  = 0; // event status / mask
  localparam int unsigned BIT_EVT_RESET = 1; // event status / mask
  // ==================================================
  // reset values
  localparam logic       RST_TRIP_SEL = 1'h0;
  localparam logic       RST_PWR_EN   = 1'h1;
  localparam logic       RST_RST_EN   = 1'h1;
  localparam logic [1:0] RST_EVT_MASK = 2'h0;
  // ==================================================
  // filter timing in oscillator_clock cycles
  localparam int unsigned CNT_W       = 6;
  localparam logic [5:0]  RST_CYCLES  = 6'h09; // nine consecutive
  localparam logic [5:0]  FLAG_CYCLES = 6'h24; // 36, inside 32..40
  localparam logic [5:0]  CNT_MAX     = 6'h3f;
  // ==================================================
  // types
  typedef enum logic [2:0] {
    ST_OFF   = 3'h1,
    ST_WATCH = 3'h2,
    ST_RESET = 3'h4
  } lvrf_state_t;
  typedef struct packed {
    logic rst_en;
    logic pwr_en;
  } lvrf_cfg_t;
  typedef struct packed {
    logic above_recovery;
    logic below_trip;
  } lvrf_cmp_t;
endpackage

// ===== lvrf_top.sv
// lvrf_top: digital filter of the supply voltage_monitor
// assumes synchronous comparator inputs and a strobe register port
//
// How it works
// R1 - monitor enable bit is one straight out of reset
// R2 - monitor acts only while monitor_power_enable is one
// R3 - reset after nine consecutive below-trip cycles, shorter dips ignored
// R4 - reset held until one cycle above recovery level
// R5 - undervoltage_flag set after 36 below cycles, inside 32 to 40
// R6 - flag zero above recovery, held between trip and recovery
// R7 - flag cleared by reset, writes to it ignored
// R8 - external reset pin driven low during monitor reset
// R9 - polled use: power on, reset off, software reads flag
// R10 - 10 percent level after reset, one selects 5 percent
// R11 - trip_tolerance_select read/write, cleared by reset
// R12 - changing tolerance resets if supply below new trip level
// R13 - interrupt request only from unmasked flag and reset events, both masked after reset
// R14 - monitor runs in wait mode, its reset wakes the system
// R15 - monitor runs in stop mode, its reset wakes the system
// R16 - two comparator inputs, counter cleared when below-trip drops
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
module lvrf_top (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_sys_rst,
  // register port
  input  wire logic [lvrf_pkg::AW-1:0] i_addr,
  input  wire logic [lvrf_pkg::DW-1:0] i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [lvrf_pkg::DW-1:0] o_rdata,
  // analog comparator
  input  wire logic                   i_below_trip,
  input  wire logic                   i_above_recovery,
  output logic                        o_trip_select,
  output logic                        o_cmp_power,
  // low power modes
  input  wire logic                   i_wait_mode,
  input  wire logic                   i_stop_mode,
  output logic                        o_wake_req,
  // reset outputs
  output logic                        o_lv_reset,
  output logic                        o_rst_pin_out,
  output logic                        o_rst_pin_oe,
  // event line
  output logic                        o_irq
);
  // ==================================================
  // state
  lvrf_pkg::lvrf_state_t state, next_state;
  lvrf_pkg::lvrf_cfg_t   cfg, next_cfg;
  lvrf_pkg::lvrf_cmp_t   cmp;
  logic [lvrf_pkg::CNT_W-1:0] cnt, next_cnt;
  logic       uv_flag, next_uv_flag;
  logic       trip_sel, next_trip_sel;
  logic [1:0] evt, next_evt;
  logic [1:0] evt_mask, next_evt_mask;
  logic [7:0] next_rdata;
  logic       next_lv_reset;
  logic       flag_rise;
  logic       reset_rise;

  // saturating increment
  function automatic logic [lvrf_pkg::CNT_W-1:0] sat_inc(
    input logic [lvrf_pkg::CNT_W-1:0] v);
    sat_inc = (v == lvrf_pkg::CNT_MAX) ? v : v + 6'h01;
  endfunction

  // address match of a strobe
  function automatic logic hit(input logic s, input logic [2:0] a,
                               input logic [2:0] k);
    hit = s && (a == k);
  endfunction

  assign cmp.below_trip     = i_below_trip;
  assign cmp.above_recovery = i_above_recovery;

  // ==================================================
  // filter state machine
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_uv_flag = uv_flag;
    case (state)
      lvrf_pkg::ST_OFF: begin
        next_cnt = 6'h00; // R2
        if (cfg.pwr_en) begin
          next_state = lvrf_pkg::ST_WATCH;
        end
      end
      lvrf_pkg::ST_WATCH: begin
        // consecutive below count, cleared on any gap
        next_cnt = cmp.below_trip ? sat_inc(cnt) : 6'h00; // R16
        if (cmp.below_trip && sat_inc(cnt) >= lvrf_pkg::FLAG_CYCLES) begin
          next_uv_flag = 1'b1; // R5
        end else if (cmp.above_recovery) begin
          next_uv_flag = 1'b0; // R6
        end
        // trip level follows the select bit, so R12 needs no extra path
        if (cmp.below_trip && cfg.rst_en &&
            sat_inc(cnt) >= lvrf_pkg::RST_CYCLES) begin
          next_state = lvrf_pkg::ST_RESET; // R3 R12 R14 R15
        end
        if (!cfg.pwr_en) begin
          next_state = lvrf_pkg::ST_OFF; // R2
          // a powered-down monitor leaves the flag alone
          next_uv_flag = uv_flag; // R2
          next_cnt   = 6'h00;
        end
      end
      lvrf_pkg::ST_RESET: begin
        next_cnt = cmp.below_trip ? sat_inc(cnt) : 6'h00; // R16
        if (cmp.below_trip && sat_inc(cnt) >= lvrf_pkg::FLAG_CYCLES) begin
          next_uv_flag = 1'b1; // R5
        end else if (cmp.above_recovery) begin
          next_uv_flag = 1'b0; // R6
        end
        if (cmp.above_recovery || !cfg.rst_en) begin
          next_state = lvrf_pkg::ST_WATCH; // R4
        end
        if (!cfg.pwr_en) begin
          next_state = lvrf_pkg::ST_OFF; // R2
          next_cnt   = 6'h00;
          // a powered-down monitor leaves the flag alone
          next_uv_flag = uv_flag; // R2
        end
      end
      default: begin
        next_state = lvrf_pkg::ST_OFF;
        next_cnt   = 6'h00;
      end
    endcase
  end

  // filter registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state   <= lvrf_pkg::ST_OFF;
      cnt     <= 6'h00;
      uv_flag <= 1'b0; // R7
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      uv_flag <= next_uv_flag;
    end
  end

  // ==================================================
  // register file and events
  assign flag_rise  = next_uv_flag && !uv_flag;
  assign reset_rise = (next_state == lvrf_pkg::ST_RESET) &&
                      (state != lvrf_pkg::ST_RESET);

  always_comb begin
    next_cfg      = cfg;
    next_trip_sel = trip_sel;
    next_evt_mask = evt_mask;
    next_evt      = evt;
    next_rdata    = 8'h00;
    // writes; the flag bit is not writable
    if (hit(i_wr, i_addr, lvrf_pkg::ADDR_STATUS_CTRL)) begin
      next_trip_sel = i_wdata[lvrf_pkg::BIT_TRIP_SEL]; // R10 R11 R7
    end
    if (hit(i_wr, i_addr, lvrf_pkg::ADDR_CONFIG)) begin
      next_cfg.pwr_en = i_wdata[lvrf_pkg::BIT_PWR_EN];
      next_cfg.rst_en = i_wdata[lvrf_pkg::BIT_RST_EN]; // R9
    end
    if (hit(i_wr, i_addr, lvrf_pkg::ADDR_EVT_MASK)) begin
      next_evt_mask = i_wdata[1:0];
    end
    // reads; event status clears on read
    case (i_addr)
      lvrf_pkg::ADDR_STATUS_CTRL: begin
        next_rdata[lvrf_pkg::BIT_TRIP_SEL] = trip_sel;
        next_rdata[lvrf_pkg::BIT_UV_FLAG]  = uv_flag;
      end
      lvrf_pkg::ADDR_CONFIG: begin
        next_rdata[lvrf_pkg::BIT_PWR_EN] = cfg.pwr_en;
        next_rdata[lvrf_pkg::BIT_RST_EN] = cfg.rst_en;
      end
      lvrf_pkg::ADDR_EVT_STATUS: next_rdata[1:0] = evt;
      lvrf_pkg::ADDR_EVT_MASK:   next_rdata[1:0] = evt_mask;
      default:                   next_rdata = 8'h00;
    endcase
    if (!i_rd) begin
      next_rdata = 8'h00;
    end
    if (hit(i_rd, i_addr, lvrf_pkg::ADDR_EVT_STATUS)) begin
      next_evt = 2'h0;
    end
    // a set in the clearing cycle wins
    if (flag_rise) begin
      next_evt[lvrf_pkg::BIT_EVT_FLAG] = 1'b1;
    end
    if (reset_rise) begin
      next_evt[lvrf_pkg::BIT_EVT_RESET] = 1'b1;
    end
  end

  assign next_lv_reset = (next_state == lvrf_pkg::ST_RESET);

  // register file and output registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cfg.pwr_en    <= lvrf_pkg::RST_PWR_EN; // R1
      cfg.rst_en    <= lvrf_pkg::RST_RST_EN;
      trip_sel      <= lvrf_pkg::RST_TRIP_SEL; // R10 R11
      evt           <= 2'h0;
      evt_mask      <= lvrf_pkg::RST_EVT_MASK; // R13
      o_rdata       <= 8'h00;
      o_trip_select <= lvrf_pkg::RST_TRIP_SEL;
      o_cmp_power   <= lvrf_pkg::RST_PWR_EN;
      o_lv_reset    <= 1'b0;
      o_rst_pin_out <= 1'b0;
      o_rst_pin_oe  <= 1'b0;
      o_wake_req    <= 1'b0;
      o_irq         <= 1'b0;
    end else begin
      cfg           <= next_cfg;
      trip_sel      <= next_trip_sel;
      evt           <= next_evt;
      evt_mask      <= next_evt_mask;
      o_rdata       <= next_rdata;
      o_trip_select <= next_trip_sel; // R12
      o_cmp_power   <= next_cfg.pwr_en; // R2
      o_lv_reset    <= next_lv_reset; // R3 R4
      o_rst_pin_out <= 1'b0; // R8
      o_rst_pin_oe  <= next_lv_reset; // R8
      o_wake_req    <= next_lv_reset &&
                       (i_wait_mode || i_stop_mode); // R14 R15
      o_irq         <= |(next_evt & next_evt_mask); // R13
    end
  end

  // ==================================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_nine_dip_reset: assert property ( // R3
    (cfg.rst_en && cfg.pwr_en && state == lvrf_pkg::ST_WATCH &&
     cnt == 6'h00 && cmp.below_trip)
    ##1 (cmp.below_trip && cfg.rst_en && cfg.pwr_en) [*8]
    |=> o_lv_reset)
    else $error("no reset after nine below cycles");
  a_short_dip_none: assert property ( // R3
    (!o_lv_reset && cnt < 6'h08) |=> !o_lv_reset)
    else $error("reset after short dip");
  a_hold_until_up: assert property ( // R4
    (o_lv_reset && !cmp.above_recovery && cfg.rst_en && cfg.pwr_en)
    |=> o_lv_reset)
    else $error("reset released below recovery");
  a_release_up: assert property ( // R4
    (o_lv_reset && cmp.above_recovery && !cmp.below_trip) |=> !o_lv_reset)
    else $error("reset kept above recovery");
  a_flag_above_zero: assert property ( // R6
    (cmp.above_recovery && !cmp.below_trip && state != lvrf_pkg::ST_OFF)
    |=> !uv_flag)
    else $error("flag set above recovery");
  a_flag_held_mid: assert property ( // R6
    (!cmp.above_recovery && !cmp.below_trip) |=> $stable(uv_flag))
    else $error("flag changed in hysteresis band");
  a_flag_not_early: assert property ( // R5
    $rose(uv_flag) |-> $past(cnt) >= 6'h1f)
    else $error("flag set before 32 cycles");
  a_flag_by_forty: assert property ( // R5
    (cfg.pwr_en && state != lvrf_pkg::ST_OFF && cnt == 6'h27 &&
     cmp.below_trip) |=> uv_flag)
    else $error("flag not set by 40 cycles");
  a_pin_follows: assert property ( // R8
    o_rst_pin_oe == o_lv_reset && !o_rst_pin_out)
    else $error("reset pin differs from monitor reset");
  a_off_silent: assert property ( // R2
    !cfg.pwr_en
    |=> (!o_lv_reset && $stable(uv_flag)))
    else $error("monitor active while powered off");
  a_flag_no_write: assert property ( // R7
    (hit(i_wr, i_addr, lvrf_pkg::ADDR_STATUS_CTRL) && cmp.below_trip == 1'b0
     && !cmp.above_recovery) |=> $stable(uv_flag))
    else $error("flag written by software");
  a_trip_sel_wr: assert property ( // R11
    hit(i_wr, i_addr, lvrf_pkg::ADDR_STATUS_CTRL)
    |=> o_trip_select == $past(i_wdata[lvrf_pkg::BIT_TRIP_SEL]))
    else $error("trip select not taken");
  a_wake_low_pwr: assert property ( // R14 R15
    ($rose(o_lv_reset) && $past(i_wait_mode || i_stop_mode)) |-> o_wake_req)
    else $error("no wake on monitor reset");
  a_no_reset_polled: assert property ( // R9
    !cfg.rst_en |=> !o_lv_reset)
    else $error("reset with reset enable off");
  a_irq_masked: assert property ( // R13
    (evt_mask == 2'h0 && !hit(i_wr, i_addr, lvrf_pkg::ADDR_EVT_MASK))
    |=> !o_irq)
    else $error("interrupt while all events masked");

  c_reset_cycle: cover property ($rose(o_lv_reset) ##[1:50] $fell(o_lv_reset));
  c_flag_polled: cover property (!cfg.rst_en && $rose(uv_flag));
  c_short_dip: cover property (cnt == 6'h05 ##1 !cmp.below_trip);
  c_sel_change: cover property ($changed(trip_sel) ##[1:20] $rose(o_lv_reset));
  c_stop_wake: cover property (i_stop_mode && $rose(o_wake_req));
endmodule

// ===== lvrf_cmp_model.sv
// lvrf_cmp_model: behavioural supply comparator at the filter's far side
// assumes the bench sets the supply level in millivolts
`timescale 1ns/1ps
module lvrf_cmp_model #(
  parameter logic [15:0] TRIP_10_MV = 16'h1090, // arbitrary level
  parameter logic [15:0] TRIP_5_MV  = 16'h1194, // arbitrary level
  parameter logic [15:0] HYST_MV    = 16'h0064  // arbitrary level
) (
  // level select and supply
  input  wire logic        i_trip_select,
  input  wire logic [15:0] i_supply_mv,
  // comparator results
  output logic             o_below_trip,
  output logic             o_above_recovery
);
  logic [15:0] trip;
  // ==================================================
  // two comparator outputs against the selected pair
  always_comb begin
    trip = i_trip_select ? TRIP_5_MV : TRIP_10_MV;
    o_below_trip = (i_supply_mv <= trip);
    o_above_recovery = (i_supply_mv > trip + HYST_MV);
  end
endmodule

// ===== lvrf_tb.sv
// lvrf_tb: self-checking bench of the voltage_monitor filter
// assumes lvrf_pkg, lvrf_top and lvrf_cmp_model are compiled first
`timescale 1ns/1ps
module lvrf_tb;
  localparam logic [15:0] LOW  = 16'h0fa0; // below both trips
  localparam logic [15:0] MID  = 16'h10c0; // between low trip and recovery
  localparam logic [15:0] BAND = 16'h1130; // between the two trips
  localparam logic [15:0] HIGH = 16'h1388; // above both recoveries
  logic       i_clk, i_sys_rst, i_wr, i_rd, i_wait_mode, i_stop_mode;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, o_rdata, d;
  logic       below, above, o_trip_select, o_cmp_power, o_wake_req;
  logic       o_lv_reset, o_rst_pin_out, o_rst_pin_oe, o_irq;
  logic [15:0] supply;
  int         errors, checks_done;
  // ==================================================
  // design and comparator
  lvrf_top lvrf_top_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_below_trip(below), .i_above_recovery(above),
    .o_trip_select(o_trip_select), .o_cmp_power(o_cmp_power),
    .i_wait_mode(i_wait_mode), .i_stop_mode(i_stop_mode),
    .o_wake_req(o_wake_req), .o_lv_reset(o_lv_reset),
    .o_rst_pin_out(o_rst_pin_out), .o_rst_pin_oe(o_rst_pin_oe),
    .o_irq(o_irq));
  lvrf_cmp_model lvrf_cmp_model_i (.i_trip_select(o_trip_select),
    .i_supply_mv(supply), .o_below_trip(below), .o_above_recovery(above));
  // ==================================================
  // clock, bus tasks and comparison
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  // set the supply, hold it n edges, settle past the last edge
  task automatic lvl(input logic [15:0] v, input int n);
    supply <= v;
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==================================================
  // watchdog
  initial begin
    #100000;
    errors++;
    conclude;
  end
  // ==================================================
  // main sequence
  initial begin
    errors = 0;
    checks_done = 0;
    i_sys_rst = 1'b1;
    {i_wr, i_rd, i_wait_mode, i_stop_mode} = 4'h0;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    supply = HIGH;
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(3'h0, d);
    chk("status", 8'h00, d);
    rd(3'h1, d);
    chk("config", 8'h03, d);
    chk("cmp_power", 8'h01, {7'h0, o_cmp_power});
    rd(3'h5, d);
    chk("unmapped", 8'h00, d);
    // eight low cycles are only a dip
    lvl(LOW, 8);
    lvl(HIGH, 4);
    chk("dip", 8'h00, {7'h0, o_lv_reset});
    i_wait_mode <= 1'b1;
    lvl(LOW, 12);
    chk("lv_reset", 8'h01, {7'h0, o_lv_reset});
    chk("pin_oe", 8'h01, {7'h0, o_rst_pin_oe});
    chk("pin_out", 8'h00, {7'h0, o_rst_pin_out});
    chk("wake_wait", 8'h01, {7'h0, o_wake_req});
    chk("irq_masked", 8'h00, {7'h0, o_irq});
    lvl(MID, 6);
    chk("held", 8'h01, {7'h0, o_lv_reset});
    lvl(HIGH, 1);
    lvl(MID, 3);
    chk("release", 8'h00, {7'h0, o_lv_reset});
    i_wait_mode <= 1'b0;
    lvl(LOW, 30);
    chk("no_wake", 8'h00, {7'h0, o_wake_req});
    lvl(MID, 2);
    rd(3'h0, d);
    chk("flag_early", 8'h00, d);
    lvl(LOW, 45);
    lvl(MID, 20);
    rd(3'h0, d);
    chk("flag_set", 8'h80, d);
    wr(3'h0, 8'h00);
    rd(3'h0, d);
    chk("flag_ro", 8'h80, d);
    lvl(HIGH, 3);
    rd(3'h0, d);
    chk("flag_clear", 8'h00, d);
    // unmask both events, then clear them by a read
    wr(3'h3, 8'h03);
    lvl(HIGH, 2);
    chk("irq", 8'h01, {7'h0, o_irq});
    rd(3'h2, d);
    chk("events", 8'h03, d);
    lvl(HIGH, 2);
    chk("irq_clear", 8'h00, {7'h0, o_irq});
    lvl(BAND, 14);
    chk("band_10", 8'h00, {7'h0, o_lv_reset});
    wr(3'h0, 8'h01);
    rd(3'h0, d);
    chk("trip_sel", 8'h01, d);
    chk("sel_out", 8'h01, {7'h0, o_trip_select});
    i_stop_mode <= 1'b1;
    lvl(BAND, 14);
    chk("sel_reset", 8'h01, {7'h0, o_lv_reset});
    chk("wake_stop", 8'h01, {7'h0, o_wake_req});
    lvl(HIGH, 3);
    i_stop_mode <= 1'b0;
    wr(3'h1, 8'h01);
    lvl(LOW, 50);
    chk("polled", 8'h00, {7'h0, o_lv_reset});
    rd(3'h0, d);
    chk("polled_flag", 8'h81, d);
    lvl(HIGH, 3);
    wr(3'h1, 8'h00);
    lvl(LOW, 50);
    chk("off_reset", 8'h00, {7'h0, o_lv_reset});
    chk("off_power", 8'h00, {7'h0, o_cmp_power});
    rd(3'h0, d);
    chk("off_flag", 8'h01, d);
    // set the flag, then show that a system reset clears it
    wr(3'h1, 8'h01);
    lvl(LOW, 40);
    rd(3'h0, d);
    chk("flag_pre_rst", 8'h81, d);
    i_sys_rst <= 1'b1;
    lvl(HIGH, 2);
    i_sys_rst <= 1'b0;
    rd(3'h0, d);
    chk("rst_status", 8'h00, d);
    chk("rst_sel_out", 8'h00, {7'h0, o_trip_select});
    rd(3'h1, d);
    chk("rst_config", 8'h03, d);
    conclude;
  end
endmodule
